// *** common/etsc_defines.svh ***
`ifndef ETSC_DEFINES_SVH
`define ETSC_DEFINES_SVH

// line-count exposure limits, in line periods
`define ETSC_LINES_MIN 32'h0000_0001
`define ETSC_LINES_MAX_SINGLE 32'h0000_1A2A
`define ETSC_LINES_MAX_DUAL 32'h0000_2FFD

// absolute exposure window in microseconds, both bounds excluded
`define ETSC_EXP_US_LOW 64'h0000_0000_0000_00C7
`define ETSC_EXP_US_HIGH 64'h0000_0000_000F_4240
`define ETSC_US_PER_S 64'h0000_0000_000F_4240
`define ETSC_US_PER_MS 64'h0000_0000_0000_03E8
`define ETSC_FRAC_LIMIT 20'hF4240

// sub-array vertical limits and alignment
`define ETSC_SUB_START_MAX 32'h0000_0A68
`define ETSC_SUB_HEIGHT_MIN 32'h0000_0008
`define ETSC_SUB_HEIGHT_MAX 32'h0000_0A70
`define ETSC_SUB_ALIGN_MSB 2

// trigger polarity parameter characters
`define ETSC_CHAR_NEG 8'h4E
`define ETSC_CHAR_POS 8'h50

// reset values
`define ETSC_RST_LINES 14'h0001
`define ETSC_RST_EXP_US 20'h02710
`define ETSC_RST_TRIG_POS 1'b0
`define ETSC_RST_SUB_START 12'h000
`define ETSC_RST_SUB_HEIGHT 12'hA70

`endif

// *** common/etsc_pkg.sv ***
package etsc_pkg;

	// setting commands after the host framing has been stripped
	typedef enum logic [2:0] {
		CMD_SHUTTER_LINES,
		CMD_EXTERNAL_SHUTTER_LINE_COUNT,
		CMD_ABSOLUTE_EXPOSURE_TIME,
		CMD_TRIGGER_POLARITY_SELECT,
		CMD_SUBARRAY_VERTICAL_START,
		CMD_SUBARRAY_VERTICAL_HEIGHT
	} etsc_op_t;

	// forms of the absolute exposure time parameter
	typedef enum logic [1:0] {
		UNIT_SEC_FRAC,
		UNIT_SEC,
		UNIT_MS,
		UNIT_US
	} etsc_unit_t;

	typedef enum logic {
		RESP_OK,
		RESP_INVALID_PARAMETER_ERROR
	} etsc_resp_t;

	typedef struct packed {
		etsc_op_t op;
		etsc_unit_t unit;
		logic [31:0] value;
		logic [19:0] frac;
	} etsc_cmd_t;

	typedef struct packed {
		logic [13:0] shutter_lines;
		logic [13:0] ext_lines;
		logic [19:0] exp_us;
		logic trig_pos;
		logic [11:0] sub_start;
		logic [11:0] sub_height;
	} etsc_cfg_t;

endpackage

// *** rtl/etsc_time_conv.sv ***
`include "etsc_defines.svh"

// turns an absolute exposure parameter into microseconds and judges it
module etsc_time_conv
	import etsc_pkg::*;
(
	input wire etsc_unit_t i_unit,
	input wire logic [31:0] i_value,
	input wire logic [19:0] i_frac,
	output logic [19:0] o_us,
	output logic o_legal
);

	logic [63:0] us_w;
	logic frac_ok;

	// 64-bit product so a huge seconds figure cannot wrap into the window
	always_comb
	begin
		frac_ok = 1'b1;
		case (i_unit)
			UNIT_SEC_FRAC:
			begin
				us_w = {32'h0000_0000, i_value} * `ETSC_US_PER_S + {44'h0, i_frac};
				frac_ok = (i_frac < `ETSC_FRAC_LIMIT);
			end
			UNIT_SEC: us_w = {32'h0000_0000, i_value} * `ETSC_US_PER_S;
			UNIT_MS: us_w = {32'h0000_0000, i_value} * `ETSC_US_PER_MS;
			default: us_w = {32'h0000_0000, i_value};
		endcase
	end

	// window is open at both ends
	always_comb
	begin
		o_legal = frac_ok && (us_w > `ETSC_EXP_US_LOW) && (us_w < `ETSC_EXP_US_HIGH);
		o_us = us_w[19:0];
	end

endmodule

// *** rtl/etsc_cmd.sv ***
`include "etsc_defines.svh"

module etsc_cmd
	import etsc_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire logic i_cmd_valid,
	input wire etsc_cmd_t i_cmd,
	input wire logic i_dual_output,
	output etsc_cfg_t o_cfg,
	output logic o_resp_valid,
	output etsc_resp_t o_resp_code
);

	etsc_cfg_t cfg_r;
	etsc_cfg_t cfg_nxt;
	logic resp_valid_r;
	etsc_resp_t resp_code_r;
	etsc_resp_t resp_code_nxt;
	logic [19:0] conv_us;
	logic conv_legal;
	logic [31:0] lines_max;

	// inclusive range test shared by the line-count and sub-array parameters
	function automatic logic f_in_range(
		input logic [31:0] v,
		input logic [31:0] lo,
		input logic [31:0] hi
	);
		f_in_range = (v >= lo) && (v <= hi);
	endfunction

	// aligned to the eight-line sub-array granularity
	function automatic logic f_aligned(input logic [31:0] v);
		f_aligned = (v[`ETSC_SUB_ALIGN_MSB:0] == 3'h0);
	endfunction

	etsc_time_conv u_conv (
		.i_unit(i_cmd.unit),
		.i_value(i_cmd.value),
		.i_frac(i_cmd.frac),
		.o_us(conv_us),
		.o_legal(conv_legal)
	);

	// readout mode picks the line-count ceiling
	always_comb
	begin
		lines_max = i_dual_output ? `ETSC_LINES_MAX_DUAL : `ETSC_LINES_MAX_SINGLE;
	end

	// decode one command; a refusal keeps cfg_nxt equal to the old value
	always_comb
	begin
		cfg_nxt = cfg_r;
		resp_code_nxt = RESP_OK;
		case (i_cmd.op)
			CMD_SHUTTER_LINES:
			begin
				if (f_in_range(i_cmd.value, `ETSC_LINES_MIN, lines_max))
					cfg_nxt.shutter_lines = i_cmd.value[13:0];
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			CMD_EXTERNAL_SHUTTER_LINE_COUNT:
			begin
				if (f_in_range(i_cmd.value, `ETSC_LINES_MIN, lines_max))
					cfg_nxt.ext_lines = i_cmd.value[13:0];
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			CMD_ABSOLUTE_EXPOSURE_TIME:
			begin
				if (conv_legal)
					cfg_nxt.exp_us = conv_us;
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			CMD_TRIGGER_POLARITY_SELECT:
			begin
				if (i_cmd.value == {24'h000000, `ETSC_CHAR_NEG})
					cfg_nxt.trig_pos = 1'b0;
				else if (i_cmd.value == {24'h000000, `ETSC_CHAR_POS})
					cfg_nxt.trig_pos = 1'b1;
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			CMD_SUBARRAY_VERTICAL_START:
			begin
				if (f_in_range(i_cmd.value, 32'h0, `ETSC_SUB_START_MAX)
					&& f_aligned(i_cmd.value))
					cfg_nxt.sub_start = i_cmd.value[11:0];
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			CMD_SUBARRAY_VERTICAL_HEIGHT:
			begin
				if (f_in_range(i_cmd.value, `ETSC_SUB_HEIGHT_MIN, `ETSC_SUB_HEIGHT_MAX)
					&& f_aligned(i_cmd.value))
					cfg_nxt.sub_height = i_cmd.value[11:0];
				else
					resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
			end
			default: resp_code_nxt = RESP_INVALID_PARAMETER_ERROR;
		endcase
	end

	// settings store; only reset or a command in this very cycle may change it
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cfg_r.shutter_lines <= `ETSC_RST_LINES;
			cfg_r.ext_lines <= `ETSC_RST_LINES;
			cfg_r.exp_us <= `ETSC_RST_EXP_US;
			cfg_r.trig_pos <= `ETSC_RST_TRIG_POS;
			cfg_r.sub_start <= `ETSC_RST_SUB_START;
			cfg_r.sub_height <= `ETSC_RST_SUB_HEIGHT;
		end
		else if (i_cmd_valid)
		begin
			cfg_r <= cfg_nxt;
		end
	end

	// one-cycle answer per command, so the host may send back to back
	always_ff @(posedge i_clock or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			resp_valid_r <= 1'b0;
			resp_code_r <= RESP_OK;
		end
		else
		begin
			resp_valid_r <= i_cmd_valid;
			if (i_cmd_valid)
				resp_code_r <= resp_code_nxt;
		end
	end

	assign o_cfg = cfg_r;
	assign o_resp_valid = resp_valid_r;
	assign o_resp_code = resp_code_r;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	sequence s_cmd(etsc_op_t op);
		i_cmd_valid && (i_cmd.op == op);
	endsequence

	sequence s_refused;
		o_resp_valid && (o_resp_code == RESP_INVALID_PARAMETER_ERROR);
	endsequence

	a_shutter_store: assert property (
		s_cmd(CMD_SHUTTER_LINES) ##0 (i_cmd.value >= 32'h1) ##0 (i_cmd.value <= 32'h1A2A)
		|=> o_cfg.shutter_lines == $past(i_cmd.value[13:0]) && o_resp_code == RESP_OK
	) else $error("shutter line count not stored");
	a_line_limit: assert property (
		s_cmd(CMD_EXTERNAL_SHUTTER_LINE_COUNT) ##0 !i_dual_output
		##0 (i_cmd.value == 32'h1A2B)
		|=> s_refused ##0 $stable(o_cfg.ext_lines)
	) else $error("single output line limit not enforced");
	a_dual_limit: assert property (
		s_cmd(CMD_EXTERNAL_SHUTTER_LINE_COUNT) ##0 i_dual_output
		##0 (i_cmd.value == 32'h2FFD)
		|=> o_cfg.ext_lines == 14'h2FFD
	) else $error("dual output line limit wrong");
	a_time_ms: assert property (
		s_cmd(CMD_ABSOLUTE_EXPOSURE_TIME) ##0 (i_cmd.unit == UNIT_MS)
		##0 (i_cmd.value == 32'h7B)
		|=> o_cfg.exp_us == 20'h1E078
	) else $error("millisecond exposure not converted");
	a_time_frac: assert property (
		s_cmd(CMD_ABSOLUTE_EXPOSURE_TIME) ##0 (i_cmd.unit == UNIT_SEC_FRAC)
		##0 (i_cmd.value == 32'h0) ##0 (i_cmd.frac == 20'h1E078)
		|=> o_cfg.exp_us == 20'h1E078 ##1 o_cfg.exp_us == $past(o_cfg.exp_us)
			|| $past(i_cmd_valid)
	) else $error("fractional second exposure not stored");
	a_time_window: assert property (
		s_cmd(CMD_ABSOLUTE_EXPOSURE_TIME) ##0 (i_cmd.unit == UNIT_US)
		##0 (i_cmd.value <= 32'hC7 || i_cmd.value >= 32'hF4240)
		|=> s_refused ##0 $stable(o_cfg.exp_us)
	) else $error("exposure outside window accepted");
	a_polarity_set: assert property (
		s_cmd(CMD_TRIGGER_POLARITY_SELECT) ##0 (i_cmd.value == 32'h50)
		|=> o_cfg.trig_pos ##0 o_resp_code == RESP_OK
	) else $error("positive polarity not selected");
	a_sub_start: assert property (
		s_cmd(CMD_SUBARRAY_VERTICAL_START) ##0 (i_cmd.value > 32'hA68)
		|=> s_refused ##0 $stable(o_cfg.sub_start)
	) else $error("sub-array start above limit accepted");
	a_sub_height: assert property (
		s_cmd(CMD_SUBARRAY_VERTICAL_HEIGHT) ##0 (i_cmd.value == 32'h0)
		|=> s_refused ##0 $stable(o_cfg.sub_height)
	) else $error("zero sub-array height accepted");
	a_sub_align: assert property (
		(s_cmd(CMD_SUBARRAY_VERTICAL_START) or s_cmd(CMD_SUBARRAY_VERTICAL_HEIGHT))
		##0 (i_cmd.value[2:0] != 3'h0)
		|=> s_refused
	) else $error("misaligned sub-array value accepted");
	a_refuse_keep: assert property (
		i_cmd_valid ##1 s_refused |-> $stable(o_cfg)
	) else $error("refused command changed settings");
	a_answer_once: assert property (
		o_resp_valid |-> $past(i_cmd_valid)
	) else $error("answer without command");

endmodule

// *** verification/etsc_host_model.sv ***
// host side: hands pre-parsed setting commands to the block
module etsc_host_model
	import etsc_pkg::*;
(
	input wire logic i_clock,
	output logic o_cmd_valid,
	output etsc_cmd_t o_cmd,
	output logic o_dual_output
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus at time zero
	initial
	begin
		o_cmd_valid = 1'b0;
		o_cmd = '0;
		o_dual_output = 1'b0;
	end

	// one command word per call, launched off the falling edge
	task automatic issue(input etsc_cmd_t c, input logic d);
		@(negedge i_clock);
		o_cmd_valid = 1'b1;
		o_cmd = c;
		o_dual_output = d;
		@(negedge i_clock);
		o_cmd_valid = 1'b0;
		// scrambled idle word, so a stale value is never mistaken for a command
		o_cmd = ~c;
	endtask
endmodule

// *** verification/testbench.sv ***
`define CHECK_EQ(got, want, msg) \
	begin \
		cmp_count++; \
		if ((got) !== (want)) \
		begin \
			n_mismatch++; \
			$display("MISMATCH t=%0t %s", $time, msg); \
		end \
	end

module testbench
	import etsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic i_clock = 1'b0;
	logic i_resetn = 1'b0;
	logic cmd_valid;
	etsc_cmd_t cmd;
	logic dual;
	etsc_cfg_t o_cfg;
	logic resp_valid;
	etsc_resp_t resp_code;
	etsc_cfg_t exp_cfg;
	int n_mismatch = 0;
	int cmp_count = 0;
	int cycles = 0;
	integer seed = 2629;
	logic [31:0] r;
	logic [31:0] v;

	always #5 i_clock = ~i_clock;

	etsc_host_model u_host (.i_clock(i_clock), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
		.o_dual_output(dual));

	etsc_cmd u_dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_cmd_valid(cmd_valid),
		.i_cmd(cmd), .i_dual_output(dual), .o_cfg(o_cfg), .o_resp_valid(resp_valid),
		.o_resp_code(resp_code));

	function automatic etsc_cfg_t rst_cfg();
		rst_cfg = '{14'h0001, 14'h0001, 20'h02710, 1'b0, 12'h000, 12'hA70};
	endfunction

	// reference judgement; updates the expected settings only on acceptance
	function automatic logic judge(input etsc_cmd_t c, input logic d, inout etsc_cfg_t m);
		logic [63:0] us;
		logic ok;
		ok = 1'b0;
		us = 64'(c.value) * (c.unit == UNIT_US ? 64'h1 : c.unit == UNIT_MS ? 64'h3E8 : 64'hF4240);
		if (c.unit == UNIT_SEC_FRAC) us = us + 64'(c.frac);
		case (c.op)
			CMD_SHUTTER_LINES, CMD_EXTERNAL_SHUTTER_LINE_COUNT:
			begin
				ok = c.value >= 32'h1 && c.value <= (d ? 32'h2FFD : 32'h1A2A);
				if (ok && c.op == CMD_SHUTTER_LINES) m.shutter_lines = c.value[13:0];
				else if (ok) m.ext_lines = c.value[13:0];
			end
			CMD_ABSOLUTE_EXPOSURE_TIME:
			begin
				ok = us > 64'hC7 && us < 64'hF4240;
				if (c.unit == UNIT_SEC_FRAC && c.frac >= 20'hF4240) ok = 1'b0;
				if (ok) m.exp_us = us[19:0];
			end
			CMD_TRIGGER_POLARITY_SELECT:
			begin
				ok = c.value == 32'h4E || c.value == 32'h50;
				if (ok) m.trig_pos = c.value == 32'h50;
			end
			CMD_SUBARRAY_VERTICAL_START:
			begin
				ok = c.value <= 32'hA68 && c.value[2:0] == 3'h0;
				if (ok) m.sub_start = c.value[11:0];
			end
			CMD_SUBARRAY_VERTICAL_HEIGHT:
			begin
				ok = c.value >= 32'h8 && c.value <= 32'hA70 && c.value[2:0] == 3'h0;
				if (ok) m.sub_height = c.value[11:0];
			end
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction

	// send one command and compare the answer one cycle later
	task automatic run(input etsc_op_t op, input etsc_unit_t u, input logic [31:0] val,
		input logic [19:0] f, input logic d);
		etsc_cmd_t c;
		logic ok;
		c = '{op, u, val, f};
		ok = judge(c, d, exp_cfg);
		u_host.issue(c, d);
		`CHECK_EQ(resp_valid, 1'b1, "no answer")
		`CHECK_EQ(resp_code, ok ? RESP_OK : RESP_INVALID_PARAMETER_ERROR, "code")
		`CHECK_EQ(o_cfg, exp_cfg, "settings")
	endtask

	task automatic test_done();
		$display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// hang guard, well above the roughly 855 cycles the run needs
	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			test_done();
		end
	end

	initial
	begin
		exp_cfg = rst_cfg();
		repeat (3) @(negedge i_clock);
		`CHECK_EQ(o_cfg, exp_cfg, "reset settings")
		`CHECK_EQ(resp_valid, 1'b0, "reset answer")
		i_resetn = 1'b1;
		run(CMD_SHUTTER_LINES, UNIT_US, 32'h1A2A, 20'h0, 1'b0);
		run(CMD_SHUTTER_LINES, UNIT_US, 32'h1A2B, 20'h0, 1'b0);
		run(CMD_EXTERNAL_SHUTTER_LINE_COUNT, UNIT_US, 32'h2FFD, 20'h0, 1'b1);
		run(CMD_EXTERNAL_SHUTTER_LINE_COUNT, UNIT_US, 32'h2FFE, 20'h0, 1'b1);
		run(CMD_EXTERNAL_SHUTTER_LINE_COUNT, UNIT_US, 32'h0, 20'h0, 1'b0);
		run(CMD_EXTERNAL_SHUTTER_LINE_COUNT, UNIT_US, 32'h1A2B, 20'h0, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_US, 32'hC7, 20'h0, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_US, 32'hC8, 20'h0, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_MS, 32'h7B, 20'h0, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_SEC, 32'h1, 20'h0, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_SEC_FRAC, 32'h0, 20'hF423F, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_SEC_FRAC, 32'h0, 20'h1E078, 1'b0);
		run(CMD_ABSOLUTE_EXPOSURE_TIME, UNIT_SEC_FRAC, 32'h0, 20'hF4240, 1'b0);
		run(CMD_TRIGGER_POLARITY_SELECT, UNIT_US, 32'h50, 20'h0, 1'b0);
		run(CMD_TRIGGER_POLARITY_SELECT, UNIT_US, 32'h4E, 20'h0, 1'b0);
		run(CMD_TRIGGER_POLARITY_SELECT, UNIT_US, 32'h4F, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_START, UNIT_US, 32'hA68, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_START, UNIT_US, 32'h101, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_START, UNIT_US, 32'hA70, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_HEIGHT, UNIT_US, 32'h8, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_HEIGHT, UNIT_US, 32'h0, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_HEIGHT, UNIT_US, 32'hA78, 20'h0, 1'b0);
		run(CMD_SUBARRAY_VERTICAL_HEIGHT, UNIT_US, 32'h204, 20'h0, 1'b0);
		run(etsc_op_t'(3'h7), UNIT_US, 32'h8, 20'h0, 1'b0);
		repeat (400)
		begin
			r = $random(seed);
			v = $unsigned($random(seed)) % (r[12] ? 32'hC00 : 32'h3300);
			if (r[11]) v[2:0] = 3'h0;
			if (r[2:0] == 3'h3) v = r[9] ? 32'h4E : (r[10] ? 32'h50 : 32'h51);
			run(etsc_op_t'(r[2:0]), etsc_unit_t'(r[4:3]), v, r[31:12], r[5]);
		end
		@(negedge i_clock);
		i_resetn = 1'b0;
		@(negedge i_clock);
		exp_cfg = rst_cfg();
		`CHECK_EQ(o_cfg, exp_cfg, "mid-run reset")
		`CHECK_EQ(resp_valid, 1'b0, "mid-run reset answer")
		i_resetn = 1'b1;
		run(CMD_SUBARRAY_VERTICAL_START, UNIT_US, 32'h100, 20'h0, 1'b0);
		test_done();
	end
endmodule
